// ===== design/tcc_pkg.sv
// Operation
// R1: counter and both compare values are 8-bit
// R2: each tick clears, increments or decrements counter
// R3: clock select zero stops the timer tick
// R4: tick from prescaler or external pin edge
// R5: software reads and writes counter at any time
// R6: counter write beats clear and count
// R7: bottom 0x00, max 0xff, top max or compare A
// R8: three-bit waveform mode split over two controls
// R9: overflow flag set per mode, interrupt source
// R10: compare match sets flag on next tick
// R11: flag and mask both set raise request
// R12: flag cleared by service or writing one
// R13: match, mode and action field drive outputs
// R14: compare buffering only in pulse-width modes
// R15: buffered compare loads only at top/bottom
// R16: compare access hits buffer or active register
// R17: force strobe acts like match, no flag/counter; ignored in pulse-width modes
// R18: counter write blocks matches for next tick
// R19: output states kept across mode change
// R20: action field changes act immediately, unbuffered
// R21: software initialises output before pin enable
// R22: software avoids writing counter onto match/bottom
// R23: reset clears the output state registers
// R24: action field zero leaves output state alone
package tcc_pkg;

  // ****************************************
  // register byte addresses
  // ****************************************
  localparam logic [7:0] ADDR_CTRL_A = 8'h00;
  localparam logic [7:0] ADDR_CTRL_B = 8'h04;
  localparam logic [7:0] ADDR_COUNT = 8'h08;
  localparam logic [7:0] ADDR_CMP_A = 8'h0c;
  localparam logic [7:0] ADDR_CMP_B = 8'h10;
  localparam logic [7:0] ADDR_FLAG = 8'h14;
  localparam logic [7:0] ADDR_MASK = 8'h18;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CA_WGM_LO = 0;  // waveform mode low bits [1:0]
  localparam int CA_COMB_LO = 4; // output action b [5:4]
  localparam int CA_COMA_LO = 6; // output action a [7:6]
  localparam int CB_CS_LO = 0;   // clock select [2:0]
  localparam int CB_WGM2 = 3;    // waveform mode high bit
  localparam int CB_FOC_B = 6;   // force strobe b
  localparam int CB_FOC_A = 7;   // force strobe a
  localparam int FL_OVF = 0;     // overflow flag
  localparam int FL_CMPA = 1;    // compare a flag
  localparam int FL_CMPB = 2;    // compare b flag

  // ****************************************
  // reset values and count limits
  // ****************************************
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_FLAGS = 3'h0;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;

  // ****************************************
  // waveform modes and clock selects
  // ****************************************
  localparam logic [2:0] WGM_NORMAL = 3'h0;
  localparam logic [2:0] WGM_CTC = 3'h2;
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam int PRE_BITS = 10;  // widest prescale divide 1024

endpackage

// ===== design/tcc_core.sv
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module tcc_core
  import tcc_pkg::*;
#(
  parameter int PRE_W = PRE_BITS
) (
  input wire logic clk,                // 200 MHz system clock
  input wire logic sys_rst,            // async reset, active high
  input wire logic psel,               // apb select
  input wire logic penable,            // apb access phase
  input wire logic pwrite,             // apb write
  input wire logic [7:0] paddr,        // apb byte address
  input wire logic [31:0] pwdata,      // apb write data
  output logic [31:0] prdata,          // apb read data
  output logic pready,                 // apb ready
  output logic pslverr,                // apb error, unmapped
  input wire logic externalCountIn,    // external count pin
  input wire logic [2:0] irqAck,       // interrupt serviced pulses
  output logic [2:0] irqReq,           // flag and mask requests
  output logic waveformOutA,           // compare output a state
  output logic waveformOutB,           // compare output b state
  output logic overrideA,              // action a nonzero, pin taken
  output logic overrideB               // action b nonzero, pin taken
);

  // ****************************************
  // parameter check
  // ****************************************
  if (PRE_W < PRE_BITS) begin : g_badPre
    $error("PRE_W too small for divide by 1024");
  end

  // ****************************************
  // state
  // ****************************************
  logic [7:0] controlRegA_q;
  logic [3:0] controlRegB_q;
  logic [7:0] counterValue_q;          // see R1
  logic [7:0] compareA_q;
  logic [7:0] compareB_q;
  logic [7:0] bufferA_q;
  logic [7:0] bufferB_q;
  logic [2:0] timerFlag_q;
  logic [2:0] timerFlag_d;
  logic [2:0] timerMask_q;
  logic countDown_q;
  logic blockMatch_q;
  logic waveA_q;
  logic waveB_q;
  logic [PRE_W-1:0] prescale_q;
  logic extSync1_q;
  logic extSync2_q;
  logic extLast_q;
  logic [31:0] prdata_q;

  // ****************************************
  // apb decode
  // ****************************************
  wire setupPhase = psel & ~penable;
  wire accessPhase = psel & penable;
  wire wrAccess = accessPhase & pwrite;
  wire selCtrlA = paddr == ADDR_CTRL_A;
  wire selCtrlB = paddr == ADDR_CTRL_B;
  wire selCount = paddr == ADDR_COUNT;
  wire selCmpA = paddr == ADDR_CMP_A;
  wire selCmpB = paddr == ADDR_CMP_B;
  wire selFlag = paddr == ADDR_FLAG;
  wire selMask = paddr == ADDR_MASK;
  wire mapped = selCtrlA | selCtrlB | selCount | selCmpA | selCmpB | selFlag | selMask;
  wire wrCtrlA = wrAccess & selCtrlA;
  wire wrCtrlB = wrAccess & selCtrlB;
  wire wrCount = wrAccess & selCount;
  wire wrCmpA = wrAccess & selCmpA;
  wire wrCmpB = wrAccess & selCmpB;
  wire wrFlag = wrAccess & selFlag;
  wire wrMask = wrAccess & selMask;
  wire [7:0] wrByte = pwdata[7:0];

  // ****************************************
  // mode decode
  // ****************************************
  wire [2:0] wgm = {controlRegB_q[CB_WGM2], controlRegA_q[CA_WGM_LO+1:CA_WGM_LO]}; // see R8
  wire isPwm = wgm[0];                 // modes 1,3,5,7
  wire isFast = wgm[0] & wgm[1];
  wire isPhase = wgm[0] & ~wgm[1];
  wire isCtc = wgm == WGM_CTC;
  wire [1:0] actA = controlRegA_q[CA_COMA_LO+1:CA_COMA_LO];
  wire [1:0] actB = controlRegA_q[CA_COMB_LO+1:CA_COMB_LO];
  wire [2:0] clockSel = controlRegB_q[CB_CS_LO+2:CB_CS_LO];
  wire [7:0] topValue = ((wgm[2] & isPwm) | isCtc) ? compareA_q : CNT_MAX; // see R7
  wire atTop = counterValue_q == topValue;
  wire atBottom = counterValue_q == CNT_BOTTOM;
  wire matchA = counterValue_q == compareA_q;
  wire matchB = counterValue_q == compareB_q;

  // ****************************************
  // timer tick select
  // ****************************************
  wire extFall = extLast_q & ~extSync2_q;
  wire extRise = ~extLast_q & extSync2_q;
  logic timerTick;
  always_comb begin // see R4
    unique case (clockSel)
      CS_STOP: timerTick = 1'b0;                 // see R3
      CS_DIV1: timerTick = 1'b1;
      CS_DIV8: timerTick = &prescale_q[2:0];
      CS_DIV64: timerTick = &prescale_q[5:0];
      CS_DIV256: timerTick = &prescale_q[7:0];
      CS_DIV1024: timerTick = &prescale_q[9:0];
      CS_EXT_FALL: timerTick = extFall;
      CS_EXT_RISE: timerTick = extRise;
    endcase
  end

  // prescaler and pin synchroniser
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prescale_q <= '0;
      extSync1_q <= 1'b0;
      extSync2_q <= 1'b0;
      extLast_q <= 1'b0;
    end else begin
      prescale_q <= prescale_q + 1'b1;
      extSync1_q <= externalCountIn;
      extSync2_q <= extSync1_q;
      extLast_q <= extSync2_q;
    end
  end

  // ****************************************
  // counter unit
  // ****************************************
  logic [7:0] countNext;
  logic downNext;
  always_comb begin // see R2
    countNext = counterValue_q + 8'h01;
    downNext = countDown_q;
    if (isPhase) begin
      if (!countDown_q && atTop) begin
        countNext = counterValue_q - 8'h01;
        downNext = 1'b1;
      end else if (countDown_q && atBottom) begin
        downNext = 1'b0;
      end else if (countDown_q) begin
        countNext = counterValue_q - 8'h01;
      end
    end else if ((isCtc | isFast) && atTop) begin
      countNext = CNT_BOTTOM;
    end
  end

  // overflow and buffer load moments
  wire overflowEv = timerTick & (isPhase ? (countDown_q & atBottom) : // see R9
                                 isFast ? atTop : counterValue_q == CNT_MAX);
  wire loadBuffers = timerTick & isPwm & atTop & (isFast | ~countDown_q); // see R15
  wire hitA = timerTick & matchA & ~blockMatch_q; // see R10 R18
  wire hitB = timerTick & matchB & ~blockMatch_q; // see R10 R18
  wire forceA = wrCtrlB & pwdata[CB_FOC_A] & ~isPwm; // see R17
  wire forceB = wrCtrlB & pwdata[CB_FOC_B] & ~isPwm; // see R17
  wire bottomEv = timerTick & isFast & atTop;

  // counter, direction and match block
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      counterValue_q <= RST_BYTE;
      countDown_q <= 1'b0;
      blockMatch_q <= 1'b0;
    end else begin
      if (wrCount) begin
        counterValue_q <= wrByte;        // see R5 R6
      end else if (timerTick) begin
        counterValue_q <= countNext;
        countDown_q <= downNext;
      end
      if (wrCount) begin
        blockMatch_q <= 1'b1;            // see R18
      end else if (timerTick) begin
        blockMatch_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // compare registers and buffers
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      compareA_q <= RST_BYTE;
      compareB_q <= RST_BYTE;
      bufferA_q <= RST_BYTE;
      bufferB_q <= RST_BYTE;
    end else begin
      if (loadBuffers) begin
        compareA_q <= bufferA_q;         // see R15
        compareB_q <= bufferB_q;
      end
      if (wrCmpA && !isPwm) compareA_q <= wrByte; // see R14 R16
      if (wrCmpB && !isPwm) compareB_q <= wrByte; // see R14 R16
      if (wrCmpA) bufferA_q <= wrByte;
      if (wrCmpB) bufferB_q <= wrByte;
    end
  end

  // ****************************************
  // waveform generator
  // ****************************************
  function automatic logic waveNext(input logic [1:0] act, input logic cur, input logic hit,
                                    input logic bottom, input logic down);
    waveNext = cur;                      // action zero keeps state, see R24
    if (!isPwm) begin
      if (hit) begin
        unique case (act)
          2'h0: waveNext = cur;
          2'h1: waveNext = ~cur;
          2'h2: waveNext = 1'b0;
          2'h3: waveNext = 1'b1;
        endcase
      end
    end else if (isPhase) begin
      if (hit && act[1]) waveNext = act[0] ^ down;
    end else if (hit && act[1]) begin
      waveNext = act[0];
    end else if (bottom && act[1]) begin
      waveNext = ~act[0];
    end
  endfunction

  // output state registers, untouched by mode writes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      waveA_q <= 1'b0;                   // see R23
      waveB_q <= 1'b0;                   // see R23
    end else begin
      waveA_q <= waveNext(actA, waveA_q, hitA | forceA, bottomEv, countDown_q); // see R13 R19 R20
      waveB_q <= waveNext(actB, waveB_q, hitB | forceB, bottomEv, countDown_q); // see R13 R19 R20
    end
  end

  // ****************************************
  // flags, mask and control registers
  // ****************************************
  wire [2:0] flagSet = {hitB, hitA, overflowEv};
  wire [2:0] flagClr = (wrFlag ? pwdata[2:0] : 3'h0) | irqAck; // see R12
  assign timerFlag_d = (timerFlag_q & ~flagClr) | flagSet;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      timerFlag_q <= RST_FLAGS;
      timerMask_q <= RST_FLAGS;
      controlRegA_q <= RST_BYTE;
      controlRegB_q <= 4'h0;
    end else begin
      timerFlag_q <= timerFlag_d;
      if (wrMask) timerMask_q <= pwdata[2:0];
      if (wrCtrlA) controlRegA_q <= wrByte;
      if (wrCtrlB) controlRegB_q <= pwdata[3:0];
    end
  end

  // ****************************************
  // read data and outputs
  // ****************************************
  logic [7:0] readByte;
  always_comb begin
    readByte = 8'h00;
    if (selCtrlA) readByte = controlRegA_q;
    if (selCtrlB) readByte = {4'h0, controlRegB_q}; // strobes read zero
    if (selCount) readByte = counterValue_q;
    if (selCmpA) readByte = isPwm ? bufferA_q : compareA_q; // see R16
    if (selCmpB) readByte = isPwm ? bufferB_q : compareB_q; // see R16
    if (selFlag) readByte = {5'h00, timerFlag_q};
    if (selMask) readByte = {5'h00, timerMask_q};
  end

  // read data captured in setup phase
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata_q <= 32'h0000_0000;
    end else if (setupPhase) begin
      prdata_q <= {24'h00_0000, readByte};
    end
  end

  // bus answers and pin-side outputs
  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = accessPhase & ~mapped;
  assign irqReq = timerFlag_q & timerMask_q; // see R11
  assign waveformOutA = waveA_q;
  assign waveformOutB = waveB_q;
  assign overrideA = |actA;
  assign overrideB = |actB;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence cntWrite_s;
    wrCount;
  endsequence

  sequence blockedTick_s;
    timerTick && blockMatch_q && !wrCount;
  endsequence

  stopNoTick_a: assert property (clockSel == CS_STOP |-> !timerTick) // see R3
    else $error("tick seen with clock stopped");
  writeWins_a: assert property (cntWrite_s |=> counterValue_q == $past(wrByte)) // see R5 R6
    else $error("counter write lost");
  matchFlag_a: assert property (hitA && !irqAck[FL_CMPA] |=> timerFlag_q[FL_CMPA]) // see R10
    else $error("compare a flag not set");
  blockNoFlag_a: assert property (blockedTick_s // see R18
                                  |=> !$rose(timerFlag_q[FL_CMPA]) && !$rose(timerFlag_q[FL_CMPB]))
    else $error("match not blocked after counter write");
  irqGate_a: assert property ($rose(timerFlag_q[FL_OVF]) && timerMask_q[FL_OVF] |-> irqReq[FL_OVF]) // see R11
    else $error("overflow request missing");
  setOverClear_a: assert property (hitB && irqAck[FL_CMPB] |=> timerFlag_q[FL_CMPB]) // see R12
    else $error("set lost to clear");
  bypassWrite_a: assert property (wrCmpA && !isPwm |=> compareA_q == $past(wrByte)) // see R14 R16
    else $error("compare a not written directly");
  bufferHold_a: assert property (isPwm && !loadBuffers && !wrCtrlA && !wrCtrlB |=> $stable(compareA_q)) // see R15
    else $error("active compare moved off top/bottom");
  forceNoFlag_a: assert property (forceA && actA == 2'h1 && !timerTick && !wrCtrlA // see R17
                                  |=> waveA_q != $past(waveA_q) && !$rose(timerFlag_q[FL_CMPA]))
    else $error("force compare misbehaved");
  ctcWrap_a: assert property (isCtc && timerTick && atTop && !wrCount && !wrCtrlA && !wrCtrlB // see R7
                              |=> counterValue_q == CNT_BOTTOM)
    else $error("ctc did not clear at top");
  zeroAction_a: assert property (actB == 2'h0 && !wrCtrlA |=> $stable(waveB_q)) // see R24
    else $error("output moved with action zero");

  // ****************************************
  // counting sequence and buffer checks
  // ****************************************
  sequence fastTop_s;
    isFast && timerTick && atTop && !wrCount && !wrCtrlA && !wrCtrlB;
  endsequence

  sequence phaseTop_s;
    isPhase && timerTick && atTop && !countDown_q && !wrCount && !wrCtrlA && !wrCtrlB;
  endsequence

  // single slope restarts from bottom after top
  fastWrap_a: assert property (fastTop_s |=> counterValue_q == CNT_BOTTOM) // see R2 R7
    else $error("fast mode did not wrap at top");
  // dual slope turns downward at top
  phaseTurn_a: assert property (phaseTop_s |=> countDown_q) // see R2
    else $error("phase mode did not turn at top");
  // overflow event leaves the flag set
  overflowSet_a: assert property (overflowEv |=> timerFlag_q[FL_OVF]) // see R9
    else $error("overflow flag not set");
  // top of a pulse-width sequence copies both buffers
  loadOnTop_a: assert property (loadBuffers // see R15
                                |=> compareA_q == $past(bufferA_q) && compareB_q == $past(bufferB_q))
    else $error("buffer not loaded at top");
  // pulse-width compare writes reach the buffer only
  bufferWrite_a: assert property (wrCmpB && isPwm // see R14 R16
                                  |=> bufferB_q == $past(wrByte) && ($stable(compareB_q) || $past(loadBuffers)))
    else $error("compare b write not buffered");
  // force strobe has no effect in pulse-width modes
  forcePwm_a: assert property (wrCtrlB && pwdata[CB_FOC_B] && isPwm && !timerTick // see R17
                               |=> $stable(waveB_q))
    else $error("force acted in pulse-width mode");
  // stopped timer holds the counter unless written
  countHold_a: assert property (clockSel == CS_STOP && !wrCount |=> $stable(counterValue_q)) // see R3
    else $error("stopped counter moved");

endmodule // tcc_core
`default_nettype wire

// ===== testbench/tcc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// far side: interrupt service and count pin
// ****************************************
module tcc_host_model (
  input wire logic clk,          // system clock
  input wire logic sysRst,       // async reset, active high
  input wire logic ackOn,        // service requests when high
  input wire logic [2:0] irqReq, // pending requests
  output logic [2:0] irqAck,     // one-cycle service pulses
  output logic countPin          // external count pin
);
  initial countPin = 1'b0;

  // service each pending request, then skip one cycle before the next pulse
  always_ff @(posedge clk or posedge sysRst) begin
    if (sysRst) begin
      irqAck <= 3'h0;
    end else begin
      irqAck <= ackOn ? (irqReq & ~irqAck) : 3'h0;
    end
  end

  // pin pulses, four clocks high and four low, ending low
  task pulses(input int n);
    for (int i = 0; i < n; i++) begin
      countPin <= 1'b1;
      repeat (4) @(posedge clk);
      countPin <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
endmodule // tcc_host_model
`default_nettype wire

// ===== testbench/tcc_core_tb.sv
`timescale 1ns/10ps
`default_nettype none
module tcc_core_tb
  import tcc_pkg::*;
;
  // ****************************************
  // signals
  // ****************************************
  logic clk = 1'b0;
  logic sysRst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic ackOn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] v;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, outA, outB, extIn, ovrA, ovrB;
  wire logic [2:0] irqReq, irqAck;
  int fails = 0;
  int compares = 0;
  int seed = 26;
  logic [32:0] expQ[$];

  always #2.5 clk = ~clk;

  tcc_core tcc_core_inst (.clk(clk), .sys_rst(sysRst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .externalCountIn(extIn), .irqAck(irqAck), .irqReq(irqReq),
    .waveformOutA(outA), .waveformOutB(outB), .overrideA(ovrA), .overrideB(ovrB));

  tcc_host_model tcc_host_model_inst (.clk(clk), .sysRst(sysRst), .ackOn(ackOn),
    .irqReq(irqReq), .irqAck(irqAck), .countPin(extIn));

  // ****************************************
  // checking and closing
  // ****************************************
  task test_done;
    if (fails == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task chk(input string n, input logic [32:0] e, input logic [32:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  // read results: error flag and data against oldest note
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) begin
      if (expQ.size() == 0) begin
        fails++;
        $display("MISMATCH read %h expected note seen none", paddr);
      end else begin
        chk($sformatf("read %h", paddr), expQ.pop_front(), {pslverr, prdata});
      end
    end
  end

  // watchdog against hangs
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    test_done;
  end

  // ****************************************
  // bus tasks
  // ****************************************
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d});
  endtask

  task rd(input logic [7:0] a, input logic [32:0] e);
    expQ.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  // run the divide-by-one tick for n+3 clocks, then stop
  task run(input int n);
    wr(ADDR_CTRL_B, 8'h01);
    repeat (n) @(posedge clk);
    wr(ADDR_CTRL_B, 8'h00);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (8) @(posedge clk);
    sysRst <= 1'b0;
    @(posedge clk);
    // reset state
    rd(ADDR_COUNT, 33'h0);
    rd(ADDR_FLAG, 33'h0);
    chk("outA", 33'h0, {32'h0, outA});
    chk("outB", 33'h0, {32'h0, outB});
    // unmapped place
    wr(8'h1c, 8'h5a);
    rd(8'h1c, 33'h100000000);
    // stopped timer keeps written values
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      wr(ADDR_COUNT, v);
      repeat (5) @(posedge clk);
      rd(ADDR_COUNT, {25'h0, v});
      v = 8'($random(seed));
      wr(ADDR_CMP_A, v);
      rd(ADDR_CMP_A, {25'h0, v});
    end
    // counter write onto compare value blocks the match
    wr(ADDR_CMP_A, 8'h30);
    wr(ADDR_CMP_B, 8'h90);
    wr(ADDR_COUNT, 8'h30);
    run(2);
    rd(ADDR_FLAG, 33'h0);
    // match sets flag, toggles output, raises masked request
    wr(ADDR_CTRL_A, 8'h40);
    wr(ADDR_CMP_A, 8'h20);
    wr(ADDR_MASK, 8'h02);
    wr(ADDR_COUNT, 8'h00);
    run(50);
    rd(ADDR_FLAG, 33'h2);
    chk("outA", 33'h1, {32'h0, outA});
    chk("irqReq", 33'h2, {30'h0, irqReq});
    wr(ADDR_FLAG, 8'h02);
    rd(ADDR_FLAG, 33'h0);
    chk("irqReq", 33'h0, {30'h0, irqReq});
    ackOn <= 1'b1;
    wr(ADDR_COUNT, 8'h00);
    run(50);
    rd(ADDR_FLAG, 33'h0);
    chk("outA", 33'h0, {32'h0, outA});
    ackOn <= 1'b0;
    // wrap from top to bottom sets overflow only
    wr(ADDR_MASK, 8'h00);
    wr(ADDR_CMP_A, 8'h80);
    wr(ADDR_CMP_B, 8'h80);
    wr(ADDR_COUNT, 8'hf0);
    run(30);
    rd(ADDR_FLAG, 33'h1);
    wr(ADDR_FLAG, 8'h07);
    // clear on compare keeps counter below compare b
    wr(ADDR_CTRL_A, 8'h02);
    wr(ADDR_CMP_A, 8'h10);
    wr(ADDR_CMP_B, 8'h30);
    wr(ADDR_COUNT, 8'h00);
    run(100);
    rd(ADDR_FLAG, 33'h2);
    wr(ADDR_FLAG, 8'h07);
    // force strobes: b sets, a with action zero does nothing
    wr(ADDR_CTRL_A, 8'h30);
    wr(ADDR_COUNT, 8'h44);
    wr(ADDR_CTRL_B, 8'hc0);
    rd(ADDR_FLAG, 33'h0);
    rd(ADDR_COUNT, 33'h44);
    chk("outB", 33'h1, {32'h0, outB});
    chk("outA", 33'h0, {32'h0, outA});
    // force ignored in pulse-width mode, state kept across modes
    wr(ADDR_CTRL_A, 8'h13);
    wr(ADDR_CTRL_B, 8'h40);
    chk("outB", 33'h1, {32'h0, outB});
    wr(ADDR_CTRL_A, 8'h10);
    chk("outB", 33'h1, {32'h0, outB});
    wr(ADDR_CTRL_B, 8'h40);
    chk("outB", 33'h0, {32'h0, outB});
    // force both with toggle actions; pin override follows action fields
    wr(ADDR_CTRL_A, 8'h50);
    chk("override", 33'h3, {31'h0, ovrB, ovrA});
    wr(ADDR_CTRL_B, 8'hc0);
    rd(ADDR_FLAG, 33'h0);
    chk("outA", 33'h1, {32'h0, outA});
    chk("outB", 33'h1, {32'h0, outB});
    // fast pulse-width: compare b waits in buffer until top, cleared at bottom
    wr(ADDR_CTRL_A, 8'h33);
    chk("override", 33'h2, {31'h0, ovrB, ovrA});
    wr(ADDR_CMP_B, 8'hf8);
    rd(ADDR_CMP_B, 33'hf8);
    wr(ADDR_COUNT, 8'hf0);
    run(80);
    rd(ADDR_FLAG, 33'h3);
    chk("outB", 33'h0, {32'h0, outB});
    // dual slope: up to top then down, match on the way down
    wr(ADDR_FLAG, 8'h07);
    wr(ADDR_CTRL_A, 8'h01);
    wr(ADDR_COUNT, 8'hfc);
    run(10);
    rd(ADDR_COUNT, 33'hf5);
    rd(ADDR_FLAG, 33'h4);
    // external pin edges, rising then falling
    wr(ADDR_CTRL_A, 8'h00);
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_CTRL_B, 8'h07);
    tcc_host_model_inst.pulses(5);
    wr(ADDR_CTRL_B, 8'h00);
    rd(ADDR_COUNT, 33'h5);
    wr(ADDR_CTRL_B, 8'h06);
    tcc_host_model_inst.pulses(3);
    wr(ADDR_CTRL_B, 8'h00);
    rd(ADDR_COUNT, 33'h8);
    test_done;
  end
endmodule // tcc_core_tb
`default_nettype wire
